// ---- hw/iptc_pkg.sv ----
// Purpose: constants for the interrupt priority and trap control block
// Assumes: AHB-Lite register access, one 32-bit word per register
// Notes: register offsets are word indexes
package iptc_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_SRC = 72;
    localparam int NUM_FLAG_REGS = 5;
    localparam int NUM_PRIO_REGS = 18;
    localparam int SRC_PER_PRIO = 4;
    localparam logic [6:0] FIRST_USER_VECTOR = 7'h08;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    // ************************************************************
    // word indexes (byte address = 4 * index)
    // ************************************************************
    localparam logic [7:0] IDX_CTRL_FIRST = 8'h00;
    localparam logic [7:0] IDX_CTRL_SECOND = 8'h01;
    localparam logic [7:0] IDX_FLAGS0 = 8'h02;
    localparam logic [7:0] IDX_ENABLES0 = 8'h07;
    localparam logic [7:0] IDX_PRIO0 = 8'h0C;
    localparam logic [7:0] IDX_PENDING = 8'h1E;
    localparam logic [7:0] IDX_STATUS_WORD = 8'h1F;
    localparam logic [7:0] IDX_CORE_CTRL = 8'h20;
    // ************************************************************
    // interrupt_control_first fields
    // ************************************************************
    localparam int B_NEST_DIS = 15;
    localparam int B_ACC_A_OVF = 14;
    localparam int B_ACC_B_OVF = 13;
    localparam int B_ACC_A_CAT = 12;
    localparam int B_ACC_B_CAT = 11;
    localparam int B_ACC_A_TE = 10;
    localparam int B_ACC_B_TE = 9;
    localparam int B_CAT_TE = 8;
    localparam int B_SHIFT_ERR = 7;
    localparam int B_DIV0_ERR = 6;
    localparam int B_DMA_ERR = 5;
    localparam int B_MATH_ERR = 4;
    localparam int B_ADDR_ERR = 3;
    localparam int B_STACK_ERR = 2;
    localparam int B_OSC_FAIL = 1;
    localparam logic [15:0] CTRL_FIRST_WMASK = 16'hFFFE;
    localparam logic [15:0] CTRL_FIRST_RESET = 16'h0000;
    // ************************************************************
    // other fields
    // ************************************************************
    localparam int B_ALT_TABLE = 15;
    localparam int B_DISI_ACTIVE = 14;
    localparam logic [15:0] CTRL_SECOND_WMASK = 16'h801F;
    localparam int B_IPL_LO = 5;
    localparam int B_IPL_TOP = 3;
    localparam int B_PEND_LEVEL_LO = 8;
endpackage : iptc_pkg

// ---- hw/iptc_top.sv ----
// Purpose: interrupt request flags, enables, priorities, arbitration and trap status
// Assumes: one clock, AHB-Lite slave with zero wait states, request and trap
//          event inputs come from logic on the same clock
// Notes: tagged rules follow
// Overview of operation
// [R1] thirty-three registers: controls, flags, enables, priorities, pending, status word, core control
// [R2] request flags set by hardware, cleared by software
// [R3] per-source enable gates every request
// [R4] three-bit priority per user source, eight levels
// [R5] pending register latches vector number and level
// [R6] latched level equals winning source priority
// [R7] fields allocated in vector order from vector eight
// [R8] low priority bits at status word bits 7:5
// [R9] top priority bit at core control bit 3
// [R10] level seven blocks all user interrupts
// [R11] top bit set blocks all user interrupts
// [R12] nesting disable makes low priority bits read-only
// [R13] nesting disable resets to zero
// [R14] accumulator overflow trap flags at bits 14, 13
// [R15] catastrophic overflow flags at bits 12, 11
// [R16] trap enables at bits 10, 9, 8
// [R17] shift error status at bit 7
// [R18] divide by zero status at bit 6
// [R19] dma error status at bit 5
// [R20] math error status on any math trap
// [R21] address, stack, oscillator status; bit 0 zero
// [R22] alternate table select at second control bit 15
// [R23] highest enabled priority wins, ties by vector order
module iptc_top (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // requests from peripherals and external inputs, one bit per source
    input wire logic [iptc_pkg::NUM_SRC-1:0] i_src_request,
    // trap events from the core, one-cycle pulses
    input wire logic i_acc_a_overflow,
    input wire logic i_acc_b_overflow,
    input wire logic i_acc_a_catastrophic,
    input wire logic i_acc_b_catastrophic,
    input wire logic i_shift_error,
    input wire logic i_divide_zero,
    input wire logic i_dma_error,
    input wire logic i_address_error,
    input wire logic i_stack_error,
    input wire logic i_oscillator_fail,
    input wire logic i_disi_active,
    // core loads a new priority level on exception entry or return
    input wire logic i_core_level_load,
    input wire logic [3:0] i_core_level,
    // to the core
    output logic o_pending_valid,
    output logic [6:0] o_pending_vector_number,
    output logic [3:0] o_pending_level,
    output logic [3:0] o_cpu_priority_level,
    output logic o_trap_request,
    output logic o_nesting_disable,
    output logic o_alternate_table_select
);
    import iptc_pkg::*;

    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0] ctrl_first;
    logic [15:0] ctrl_second;
    logic [16*NUM_FLAG_REGS-1:0] request_flags;
    logic [16*NUM_FLAG_REGS-1:0] source_enables;
    logic [2:0] source_priorities [NUM_SRC];
    logic [2:0] cpu_priority_level;
    logic cpu_priority_top_bit;
    logic [6:0] pending_vector_number;
    logic [3:0] pending_level;

    // bus pipeline
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] addr_idx;
    logic addr_phase;
    logic [15:0] wdata;

    // arbitration
    logic win_found;
    logic [6:0] win_idx;
    logic [2:0] win_level;
    logic [15:0] trap_set;

    // true when idx falls in [base, base+count)
    function automatic logic in_range(input logic [7:0] idx, input logic [7:0] base,
                                      input int count);
        in_range = (idx >= base) && (idx < base + 8'(count));
    endfunction

    assign addr_idx = i_haddr[9:2];
    assign addr_phase = i_hsel && i_hready && i_htrans[1];
    assign wdata = i_hwdata[15:0];

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    // zero wait states; every response is OKAY
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // address phase captured, write applied in the data phase
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
        end else begin
            wr_pend <= addr_phase && i_hwrite;
            wr_idx <= addr_idx;
        end
    end

    // read data is sampled at the address phase; a read right behind a
    // write to the same word would see the old value, the bus master's
    // idle cycle between transfers hides this
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_phase && !i_hwrite) begin
            o_hrdata <= {16'h0000, read_word(addr_idx)}; // [R1]
        end
    end

    function automatic logic [15:0] read_word(input logic [7:0] idx);
        logic [15:0] v;
        int k;
        v = 16'h0000;
        k = 0;
        if (idx == IDX_CTRL_FIRST) begin
            v = ctrl_first & CTRL_FIRST_WMASK; // [R21]
        end else if (idx == IDX_CTRL_SECOND) begin
            v = ctrl_second & CTRL_SECOND_WMASK;
            v[B_DISI_ACTIVE] = i_disi_active;
        end else if (in_range(idx, IDX_FLAGS0, NUM_FLAG_REGS)) begin
            k = int'(idx - IDX_FLAGS0);
            v = request_flags[16*k +: 16];
        end else if (in_range(idx, IDX_ENABLES0, NUM_FLAG_REGS)) begin
            k = int'(idx - IDX_ENABLES0);
            v = source_enables[16*k +: 16];
        end else if (in_range(idx, IDX_PRIO0, NUM_PRIO_REGS)) begin
            k = int'(idx - IDX_PRIO0);
            for (int j = 0; j < SRC_PER_PRIO; j++) begin
                v[4*j +: 3] = source_priorities[SRC_PER_PRIO*k + j]; // [R7]
            end
        end else if (idx == IDX_PENDING) begin
            v[6:0] = pending_vector_number; // [R5]
            v[B_PEND_LEVEL_LO +: 4] = pending_level;
        end else if (idx == IDX_STATUS_WORD) begin
            v[B_IPL_LO +: 3] = cpu_priority_level; // [R8]
        end else if (idx == IDX_CORE_CTRL) begin
            v[B_IPL_TOP] = cpu_priority_top_bit; // [R9]
        end
        return v;
    endfunction

    // ************************************************************
    // request flags and enables
    // ************************************************************
    // hardware set wins over a software clear in the same cycle
    generate
        for (genvar r = 0; r < NUM_FLAG_REGS; r++) begin : g_flag_regs
            logic [15:0] hw_set;
            logic [15:0] valid_bits;
            for (genvar b = 0; b < 16; b++) begin : g_bits
                if (16*r + b < NUM_SRC) begin : g_used
                    assign hw_set[b] = i_src_request[16*r + b];
                    assign valid_bits[b] = 1'b1;
                end else begin : g_unused
                    assign hw_set[b] = 1'b0;
                    assign valid_bits[b] = 1'b0;
                end
            end
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    request_flags[16*r +: 16] <= 16'h0000;
                end else if (wr_pend && wr_idx == IDX_FLAGS0 + 8'(r)) begin
                    request_flags[16*r +: 16] <= (wdata & valid_bits) | hw_set; // [R2]
                end else begin
                    request_flags[16*r +: 16] <= request_flags[16*r +: 16] | hw_set; // [R2]
                end
            end
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    source_enables[16*r +: 16] <= 16'h0000;
                end else if (wr_pend && wr_idx == IDX_ENABLES0 + 8'(r)) begin
                    source_enables[16*r +: 16] <= wdata & valid_bits; // [R3]
                end
            end
        end
    endgenerate

    // ************************************************************
    // priorities
    // ************************************************************
    // four sources per word, three bits each in nibble order
    generate
        for (genvar s = 0; s < NUM_SRC; s++) begin : g_prio
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    source_priorities[s] <= PRIO_RESET;
                end else if (wr_pend && wr_idx == IDX_PRIO0 + 8'(s / SRC_PER_PRIO)) begin
                    source_priorities[s] <= wdata[4*(s % SRC_PER_PRIO) +: 3]; // [R4] [R7]
                end
            end
        end
    endgenerate

    // ************************************************************
    // control registers and trap status
    // ************************************************************
    // trap events, overflow ones gated by their enables
    always_comb begin
        trap_set = 16'h0000;
        trap_set[B_ACC_A_OVF] = i_acc_a_overflow && ctrl_first[B_ACC_A_TE]; // [R14] [R16]
        trap_set[B_ACC_B_OVF] = i_acc_b_overflow && ctrl_first[B_ACC_B_TE]; // [R14] [R16]
        trap_set[B_ACC_A_CAT] = i_acc_a_catastrophic && ctrl_first[B_CAT_TE]; // [R15] [R16]
        trap_set[B_ACC_B_CAT] = i_acc_b_catastrophic && ctrl_first[B_CAT_TE]; // [R15] [R16]
        trap_set[B_SHIFT_ERR] = i_shift_error; // [R17]
        trap_set[B_DIV0_ERR] = i_divide_zero; // [R18]
        trap_set[B_DMA_ERR] = i_dma_error; // [R19]
        trap_set[B_MATH_ERR] = |trap_set[B_ACC_A_OVF:B_ACC_B_CAT] || i_shift_error
                               || i_divide_zero; // [R20]
        trap_set[B_ADDR_ERR] = i_address_error; // [R21]
        trap_set[B_STACK_ERR] = i_stack_error; // [R21]
        trap_set[B_OSC_FAIL] = i_oscillator_fail; // [R21]
    end

    // status bits are software writable, but a new trap always wins
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_first <= CTRL_FIRST_RESET; // [R13]
        end else if (wr_pend && wr_idx == IDX_CTRL_FIRST) begin
            ctrl_first <= (wdata & CTRL_FIRST_WMASK) | trap_set; // [R13]
        end else begin
            ctrl_first <= ctrl_first | trap_set;
        end
    end

    // alternate table select and edge polarity bits
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_second <= 16'h0000; // [R22]
        end else if (wr_pend && wr_idx == IDX_CTRL_SECOND) begin
            ctrl_second <= wdata & CTRL_SECOND_WMASK; // [R22]
        end
    end

    // one-cycle trap notice to the core
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_trap_request <= 1'b0;
        end else begin
            o_trap_request <= |trap_set;
        end
    end

    // ************************************************************
    // cpu priority level
    // ************************************************************
    // core loads take precedence over software writes in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_priority_level <= 3'h0;
        end else if (i_core_level_load) begin
            cpu_priority_level <= i_core_level[2:0];
        end else if (wr_pend && wr_idx == IDX_STATUS_WORD && !ctrl_first[B_NEST_DIS]) begin
            cpu_priority_level <= wdata[B_IPL_LO +: 3]; // [R8] [R12]
        end
    end

    // top bit: software can only clear it, so traps stay unmaskable
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_priority_top_bit <= 1'b0;
        end else if (i_core_level_load) begin
            cpu_priority_top_bit <= i_core_level[3];
        end else if (wr_pend && wr_idx == IDX_CORE_CTRL && !wdata[B_IPL_TOP]) begin
            cpu_priority_top_bit <= 1'b0; // [R9]
        end
    end

    // ************************************************************
    // arbitration
    // ************************************************************
    // strict greater-than keeps the lowest vector on ties; starting from
    // the cpu level drops everything at or below it, so level 7 blocks all
    always_comb begin
        win_found = 1'b0;
        win_idx = 7'h00;
        win_level = cpu_priority_level; // [R10]
        for (int i = 0; i < NUM_SRC; i++) begin
            if (request_flags[i] && source_enables[i]
                && source_priorities[i] > win_level) begin // [R3] [R23]
                win_found = 1'b1;
                win_idx = 7'(i);
                win_level = source_priorities[i];
            end
        end
    end

    // pending register loads the winner each cycle; it holds its last value while nothing wins or the top bit is set
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending_vector_number <= 7'h00;
            pending_level <= 4'h0;
            o_pending_valid <= 1'b0;
        end else if (win_found && !cpu_priority_top_bit) begin // [R11]
            pending_vector_number <= win_idx + FIRST_USER_VECTOR; // [R5] [R7]
            pending_level <= {1'b0, win_level}; // [R6]
            o_pending_valid <= 1'b1;
        end else begin
            o_pending_valid <= 1'b0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_pending_vector_number = pending_vector_number;
    assign o_pending_level = pending_level;
    assign o_cpu_priority_level = {cpu_priority_top_bit, cpu_priority_level}; // [R11]
    assign o_nesting_disable = ctrl_first[B_NEST_DIS]; // [R13]
    assign o_alternate_table_select = ctrl_second[B_ALT_TABLE]; // [R22]

endmodule // iptc_top

// ---- testbench/iptc_top_asserts.sv ----
// Purpose: port-level checks for iptc_top
// Assumes: zero-wait bus, outputs registered
// Notes: bound into every iptc_top instance
module iptc_top_asserts (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic i_dma_error,
    input wire logic i_address_error,
    input wire logic i_stack_error,
    input wire logic i_oscillator_fail,
    input wire logic i_core_level_load,
    input wire logic [3:0] i_core_level,
    input wire logic o_pending_valid,
    input wire logic [6:0] o_pending_vector_number,
    input wire logic [3:0] o_pending_level,
    input wire logic [3:0] o_cpu_priority_level,
    input wire logic o_trap_request,
    input wire logic o_nesting_disable,
    input wire logic o_alternate_table_select
);
    timeunit 1ns;
    timeprecision 1ps;
    import iptc_pkg::*;
    // ************************************************************
    // write address phase decode
    // ************************************************************
    wire logic wr_ap = i_hsel && i_hready && i_htrans[1] && i_hwrite;
    wire logic [7:0] ap_idx = i_haddr[9:2];
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // data lands one edge after the address phase
    bus_okay_a: assert property (o_hreadyout && !o_hresp && o_hrdata[31:16] == 16'h0)
        else $error("bus answer not ready or not okay");
    nest_out_a: assert property (wr_ap && ap_idx == IDX_CTRL_FIRST |=> ##1
        o_nesting_disable == $past(i_hwdata[15])) else $error("nesting output wrong");
    alt_out_a: assert property (wr_ap && ap_idx == IDX_CTRL_SECOND |=> ##1
        o_alternate_table_select == $past(i_hwdata[15])) else $error("table select wrong");
    top_blocks_a: assert property (o_cpu_priority_level[3] |=> !o_pending_valid)
        else $error("pending while top level bit set");
    lvl7_blocks_a: assert property (o_cpu_priority_level[2:0] == 3'h7 |=> !o_pending_valid)
        else $error("pending at level seven");
    level_above_a: assert property (o_pending_valid |->
        o_pending_level > $past(o_cpu_priority_level)) else $error("pending level too low");
    vec_range_a: assert property (o_pending_valid |-> !o_pending_level[3] &&
        o_pending_vector_number inside {[8:79]}) else $error("pending vector out of range");
    trap_pulse_a: assert property (i_dma_error || i_address_error || i_stack_error ||
        i_oscillator_fail |=> o_trap_request) else $error("trap request missing");
    core_load_a: assert property (i_core_level_load |=>
        o_cpu_priority_level == $past(i_core_level)) else $error("core level not loaded");
    nest_lock_a: assert property (wr_ap && ap_idx == IDX_STATUS_WORD && o_nesting_disable
        ##1 !i_core_level_load |=> $stable(o_cpu_priority_level[2:0]))
        else $error("level changed while locked");
endmodule // iptc_top_asserts

bind iptc_top iptc_top_asserts u_chk (.*);

// ---- testbench/iptc_core_model.sv ----
// Purpose: processor core model that loads the cpu level
// Assumes: one clock shared with the controller
// Notes: level bus only meaningful with the strobe
module iptc_core_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_pend_valid,
    input wire logic [3:0] i_pend_level,
    input wire logic i_take,
    input wire logic i_set,
    input wire logic [3:0] i_set_level,
    output logic o_load,
    output logic [3:0] o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // forced level beats exception entry; garbage level when idle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_load <= 1'b0;
            o_level <= 4'h0;
        end else if (i_set) begin
            o_load <= 1'b1;
            o_level <= i_set_level;
        end else if (i_take && i_pend_valid && !o_load) begin
            o_load <= 1'b1;
            o_level <= i_pend_level;
        end else begin
            o_load <= 1'b0;
            o_level <= ~o_level;
        end
    end
endmodule // iptc_core_model

// ---- testbench/iptc_tb_top.sv ----
// Purpose: self-checking bench for iptc_top
// Assumes: zero-wait AHB-Lite slave, single word transfers
// Notes: one idle edge after each transfer
module iptc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import iptc_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk = 1'b0;
    logic rst_n, hsel, hwrite, hready, hresp, take, set_en, load;
    logic pend_v, trap_req, nest, alt;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [NUM_SRC-1:0] req;
    logic [9:0] trap;
    logic [3:0] set_lvl, core_lvl, pend_lvl, cpu_lvl;
    logic [6:0] pend_vec;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    iptc_top dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_src_request(req), .i_acc_a_overflow(trap[0]), .i_acc_b_overflow(trap[1]),
        .i_acc_a_catastrophic(trap[2]), .i_acc_b_catastrophic(trap[3]),
        .i_shift_error(trap[4]), .i_divide_zero(trap[5]), .i_dma_error(trap[6]),
        .i_address_error(trap[7]), .i_stack_error(trap[8]), .i_oscillator_fail(trap[9]),
        .i_disi_active(1'b1), .i_core_level_load(load), .i_core_level(core_lvl),
        .o_pending_valid(pend_v), .o_pending_vector_number(pend_vec),
        .o_pending_level(pend_lvl), .o_cpu_priority_level(cpu_lvl),
        .o_trap_request(trap_req), .o_nesting_disable(nest),
        .o_alternate_table_select(alt));
    iptc_core_model core (.i_sys_clk(clk), .i_rst_n(rst_n), .i_pend_valid(pend_v),
        .i_pend_level(pend_lvl), .i_take(take), .i_set(set_en), .i_set_level(set_lvl),
        .o_load(load), .o_level(core_lvl));
    // 200 MHz clock and a hang guard far above the run length
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // address phase held until ready, then data phase until ready
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        hsel <= 1'b0;
        @(posedge clk); // a read right after a write would see stale data
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [15:0] exp, input string what);
        bus(1'b0, idx, 32'h0);
        check(what, rd[15:0], exp);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rdc(IDX_CTRL_FIRST, 16'h0000, "ctrl_first");
        rdc(IDX_CTRL_SECOND, 16'h4000, "ctrl_second");
        rdc(IDX_PRIO0 + 8'h11, 16'h4444, "prio17");
        rdc(IDX_PENDING, 16'h0000, "pending");
        rdc(IDX_CORE_CTRL, 16'h0000, "core_ctrl");
        rdc(8'h3F, 16'h0000, "unmapped");
        bus(1'b1, IDX_CTRL_FIRST, 32'h0000FFFF);
        rdc(IDX_CTRL_FIRST, 16'hFFFE, "ctrl_first_all");
        bus(1'b1, IDX_CTRL_FIRST, 32'h0);
        bus(1'b1, IDX_CTRL_SECOND, 32'h8000);
        check("alt_table", {15'h0, alt}, 16'h1);
        bus(1'b1, IDX_CTRL_SECOND, 32'h0);
    endtask
    task automatic t_arb();
        bus(1'b1, IDX_ENABLES0, 32'h3);
        bus(1'b1, IDX_PRIO0, 32'h0755);
        req[2:0] <= 3'b111;
        @(posedge clk);
        req <= '0;
        rdc(IDX_FLAGS0, 16'h0007, "flags0");
        rdc(IDX_PENDING, 16'h0508, "tie_lowest");
        bus(1'b1, IDX_PRIO0, 32'h0765);
        rdc(IDX_PENDING, 16'h0609, "higher_wins");
        check("pend_vec", {9'h0, pend_vec}, 16'h9);
        bus(1'b1, IDX_STATUS_WORD, 32'h00A0);
        rdc(IDX_PENDING, 16'h0609, "above_cpu");
        bus(1'b1, IDX_STATUS_WORD, 32'h00C0);
        rdc(IDX_STATUS_WORD, 16'h00C0, "status_word");
        check("masked", {15'h0, pend_v}, 16'h0);
        bus(1'b1, IDX_STATUS_WORD, 32'h0);
        take <= 1'b1;
        repeat (2) @(posedge clk);
        take <= 1'b0;
        repeat (2) @(posedge clk);
        check("entry_level", {12'h0, cpu_lvl}, 16'h6);
        set_en <= 1'b1;
        set_lvl <= 4'h8;
        @(posedge clk);
        set_en <= 1'b0;
        bus(1'b1, IDX_STATUS_WORD, 32'h0);
        check("top_masked", {15'h0, pend_v}, 16'h0);
        bus(1'b1, IDX_CORE_CTRL, 32'h0008);
        rdc(IDX_CORE_CTRL, 16'h0008, "top_kept");
        bus(1'b1, IDX_CORE_CTRL, 32'h0);
        rdc(IDX_PENDING, 16'h0609, "top_cleared");
        bus(1'b1, IDX_FLAGS0, 32'h0);
        rdc(IDX_FLAGS0, 16'h0000, "flags_clear");
        check("none", {15'h0, pend_v}, 16'h0);
    endtask
    task automatic t_nest();
        bus(1'b1, IDX_CTRL_FIRST, 32'h8000);
        check("nest_out", {15'h0, nest}, 16'h1);
        bus(1'b1, IDX_STATUS_WORD, 32'h00E0);
        rdc(IDX_STATUS_WORD, 16'h0000, "locked");
        bus(1'b1, IDX_CTRL_FIRST, 32'h0);
        bus(1'b1, IDX_STATUS_WORD, 32'h00E0);
        rdc(IDX_STATUS_WORD, 16'h00E0, "unlocked");
        bus(1'b1, IDX_STATUS_WORD, 32'h0);
    endtask
    // each trap event once with gates open, then overflow with gates shut
    task automatic t_traps();
        int bitn [10] = '{14, 13, 12, 11, 7, 6, 5, 3, 2, 1};
        logic [15:0] e;
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, IDX_CTRL_FIRST, 32'h0700);
            trap[i] <= 1'b1;
            @(posedge clk);
            trap <= '0;
            bus(1'b0, IDX_CTRL_FIRST, 32'h0);
            e = 16'h0700 | (16'h1 << bitn[i]) | ((i < 6) ? 16'h0010 : 16'h0);
            check("trap_status", rd[15:0], e);
        end
        bus(1'b1, IDX_CTRL_FIRST, 32'h0);
        trap <= 10'h00F;
        @(posedge clk);
        trap <= '0;
        rdc(IDX_CTRL_FIRST, 16'h0000, "gated_off");
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = '0;
        hwdata = '0;
        req = '0;
        trap = '0;
        take = 1'b0;
        set_en = 1'b0;
        set_lvl = 4'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_arb();
        t_nest();
        t_traps();
        summarize();
    end
endmodule // iptc_tb_top
